// ---- rtl/bfs_fault_frame.sv ----
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - a bus fault pushes exactly twelve 16-bit words on supervisor stack
// - three frame variants differ in type and multi-move flags, move count byte and stack placement
// - status word: type bit 15, multi-move bit 14, bit 13 zero, rest bus state
// - transfer count word at offset 14: revision byte and move count byte
// - return compares stacked revision with own before reusing state
// - move count reloaded only when stacked multi-move flag set
// - prefetch and ordinary operand faults write flag pair 00
// - multi-register move operand faults write flag pair 01
// - faults during exception processing write 10, frame below faulted one
// - nested fault stacking starts at earlier stack pointer minus six
// - short faulted frame: no current pc, count at 10, status at 12
// - dynamically sized cycle reports upper byte address as fault address
// - frame layout: sr 0, pc 2, format 6, addr 8, data c, pc 10, count 14, status 16
// - format word carries code c in top four bits plus vector offset
// - hidden state is only bus controller state and one register
// - trace raises exception after each instruction, or only on flow change
// - opcodes 4848 through 484f are software breakpoints
// - a-line and f-line opcodes take their own vectors
// - continued move refetches without new address, same mask rescans
module bfs_fault_frame
	import bfs_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h01 // arbitrary value
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// fault capture from bus controller
	input wire logic faultReq,
	input wire logic inException,
	input wire logic inMultiMove,
	input wire logic dynSized,
	input wire logic [31:0] cycleAddr,
	input wire logic [12:0] busState,
	input wire logic [31:0] dataHold,
	input wire logic [15:0] srWord,
	input wire logic [31:0] retPc,
	input wire logic [31:0] curPc,
	input wire logic [7:0] vecOffset,
	input wire logic [7:0] moveCount,
	input wire logic [31:0] stackPtr,
	input wire logic [31:0] priorSp,
	input wire logic shortFaulted,
	// return request
	input wire logic restoreReq,
	input wire logic [15:0] stkXfer,
	input wire logic [15:0] stkFsw,
	// instruction stream
	input wire logic [15:0] opcode,
	input wire logic opDone,
	input wire logic flowChange,
	// stack write port
	output logic stkWr,
	output logic [31:0] stkAddr,
	output logic [15:0] stkData,
	output logic [31:0] newSp,
	output logic frameDone,
	// restore results
	output logic moveLoad,
	output logic [7:0] moveReload,
	output logic moveContinue,
	output logic restoreOk,
	// exception requests
	output logic excReq,
	output logic [7:0] excVec
);
	typedef enum {ST_IDLE, ST_PUSH} bfs_state_t;
	typedef struct packed {
		bfs_state_t st;
		logic [3:0] cnt;
		logic [31:0] addr;
		logic [31:0] faultAddr;
		logic [31:0] dataHold;
		logic [15:0] sr;
		logic [31:0] retPc;
		logic [31:0] curPc;
		logic [15:0] fmt;
		logic [15:0] xfer;
		logic [15:0] fsw;
		logic shortFr;
		logic [1:0] ctrl;
		logic stkWr;
		logic [31:0] stkAddr;
		logic [15:0] stkData;
		logic [31:0] newSp;
		logic frameDone;
		logic moveLoad;
		logic [7:0] moveReload;
		logic moveContinue;
		logic restoreOk;
		logic excReq;
		logic [7:0] excVec;
		logic [15:0] rdata;
	} bfs_regs_t;
	bfs_regs_t r_q, r_d;
	logic [15:0] wordOut;
	logic [7:0] offNow;
	logic isBreak, isLine;
	logic [7:0] lineVec;
	logic [1:0] kind;
	logic [31:0] base;

	bfs_op_decode u_dec (
		.opcode(opcode),
		.opValid(opDone),
		.isBreak(isBreak),
		.isLine(isLine),
		.lineVec(lineVec)
	);

	// offset of the word being written, counted from the frame's final top
	// short frames are remapped inside the word mux, so the count alone sets the offset
	assign offNow = {3'h0, r_q.cnt, 1'b0};

	bfs_frame_word u_word (
		.srWord(r_q.sr),
		.retPc(r_q.retPc),
		.fmtWord(r_q.fmt),
		.faultAddr(r_q.faultAddr),
		.dataHold(r_q.dataHold),
		.curPc(r_q.curPc),
		.xferWord(r_q.xfer),
		.fswWord(r_q.fsw),
		.shortFrame(r_q.shortFr),
		.offset(offNow),
		.word(wordOut)
	);

	always_comb begin
		kind = inException ? KIND_NESTED : (inMultiMove ? KIND_MULTI : KIND_NORMAL);
		base = inException ? priorSp - NESTED_GAP : stackPtr;
	end

	always_comb begin
		r_d = r_q;
		r_d.stkWr = 1'b0;
		r_d.frameDone = 1'b0;
		r_d.moveLoad = 1'b0;
		r_d.restoreOk = 1'b0;
		r_d.excReq = 1'b0;
		r_d.rdata = 16'h0000;
		case (r_q.st)
			ST_IDLE: begin
				if (faultReq) begin
					// only bus state and the count register are kept as hidden state
					r_d.fsw = {kind, 1'b0, busState};
					// dynamic cycles report the upper byte address
					r_d.faultAddr = dynSized ? {cycleAddr[31:1], 1'b0} : cycleAddr;
					r_d.dataHold = dataHold;
					r_d.sr = srWord;
					r_d.retPc = retPc;
					r_d.curPc = curPc;
					r_d.fmt = {FMT_BUS_FAULT, 4'h0, vecOffset};
					r_d.xfer = {REVISION, (kind == KIND_MULTI) ? moveCount : 8'h00};
					r_d.shortFr = inException && shortFaulted;
					r_d.cnt = 4'(WORDS_FRAME - 1);
					r_d.addr = base - 32'h0000_0002;
					r_d.st = ST_PUSH;
				end else if (restoreReq) begin
					if (stkXfer[15:8] != REVISION) begin
						r_d.excReq = 1'b1;
						r_d.excVec = VEC_FORMAT;
					end else begin
						r_d.restoreOk = 1'b1;
						// a cleared flag means the handler wants a full restart
						r_d.moveContinue = stkFsw[FSW_MULTI];
						r_d.moveLoad = stkFsw[FSW_MULTI];
						r_d.moveReload = stkXfer[7:0];
					end
				end else if (opDone && isBreak) begin
					r_d.excReq = 1'b1;
					r_d.excVec = VEC_ILLEGAL;
				end else if (opDone && isLine) begin
					r_d.excReq = 1'b1;
					r_d.excVec = lineVec;
				end else if (opDone && r_q.ctrl[CTRL_TRACE] &&
					(!r_q.ctrl[CTRL_FLOW] || flowChange)) begin
					r_d.excReq = 1'b1;
					r_d.excVec = VEC_TRACE;
				end
			end
			ST_PUSH: begin
				r_d.stkWr = 1'b1;
				r_d.stkAddr = r_q.addr;
				r_d.stkData = wordOut;
				r_d.addr = r_q.addr - 32'h0000_0002;
				if (r_q.cnt == 4'h0) begin
					r_d.newSp = r_q.addr;
					r_d.frameDone = 1'b1;
					r_d.st = ST_IDLE;
				end else begin
					r_d.cnt = r_q.cnt - 4'h1;
				end
			end
			default: r_d.st = ST_IDLE;
		endcase
		if (regWr && regAddr == REG_CTRL) begin
			r_d.ctrl = regWdata[1:0];
		end
		if (regWr && regAddr == REG_FSW && r_q.st == ST_IDLE && !faultReq) begin
			r_d.fsw = {regWdata[15:14], 1'b0, regWdata[12:0]};
		end
		if (regRd) begin
			case (regAddr)
				REG_CTRL: r_d.rdata = {14'h0000, r_q.ctrl};
				REG_FSW: r_d.rdata = r_q.fsw;
				REG_STATUS: r_d.rdata = {15'h0000, r_q.st == ST_PUSH};
				REG_COUNT: r_d.rdata = {12'h000, r_q.cnt};
				default: r_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			r_q <= '{st: ST_IDLE, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	assign regRdata = r_q.rdata;
	assign stkWr = r_q.stkWr;
	assign stkAddr = r_q.stkAddr;
	assign stkData = r_q.stkData;
	assign newSp = r_q.newSp;
	assign frameDone = r_q.frameDone;
	assign moveLoad = r_q.moveLoad;
	assign moveReload = r_q.moveReload;
	assign moveContinue = r_q.moveContinue;
	assign restoreOk = r_q.restoreOk;
	assign excReq = r_q.excReq;
	assign excVec = r_q.excVec;

	// pushes counted since a fault was taken
	logic [4:0] pushCnt;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pushCnt <= 5'h00;
		end else if (faultReq && r_q.st == ST_IDLE) begin
			pushCnt <= 5'h00;
		end else if (r_q.stkWr) begin
			pushCnt <= pushCnt + 5'h01;
		end
	end

	property p_frame_len;
		@(posedge ref_clk) disable iff (!rst_b)
		r_q.frameDone |-> pushCnt == 5'd11;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not twelve words");

	property p_bit13;
		@(posedge ref_clk) disable iff (!rst_b)
		r_q.st == ST_PUSH |-> r_q.fsw[FSW_ZERO] == 1'b0;
	endproperty
	a_bit13: assert property (p_bit13) else $error("status bit 13 set");

	property p_kind_multi;
		@(posedge ref_clk) disable iff (!rst_b)
		(r_q.st == ST_IDLE && faultReq && !inException && inMultiMove)
		|=> r_q.fsw[15:14] == KIND_MULTI;
	endproperty
	a_kind_multi: assert property (p_kind_multi) else $error("multi move pair wrong");

	property p_kind_norm;
		@(posedge ref_clk) disable iff (!rst_b)
		(r_q.st == ST_IDLE && faultReq && !inException && !inMultiMove)
		|=> r_q.fsw[15:14] == KIND_NORMAL;
	endproperty
	a_kind_norm: assert property (p_kind_norm) else $error("normal pair wrong");

	property p_nested;
		@(posedge ref_clk) disable iff (!rst_b)
		(r_q.st == ST_IDLE && faultReq && inException)
		|=> r_q.fsw[15:14] == KIND_NESTED && r_q.addr == $past(priorSp) - 32'h8;
	endproperty
	a_nested: assert property (p_nested) else $error("nested frame placement wrong");

	property p_downward;
		@(posedge ref_clk) disable iff (!rst_b)
		r_q.stkWr && $past(r_q.stkWr) |-> r_q.stkAddr == $past(r_q.stkAddr) - 32'h2;
	endproperty
	a_downward: assert property (p_downward) else $error("stack not descending");

	property p_format;
		@(posedge ref_clk) disable iff (!rst_b)
		r_q.st == ST_PUSH |-> r_q.fmt[15:12] == FMT_BUS_FAULT;
	endproperty
	a_format: assert property (p_format) else $error("format code wrong");

	property p_revision;
		@(posedge ref_clk) disable iff (!rst_b)
		(r_q.st == ST_IDLE && !faultReq && restoreReq && stkXfer[15:8] != REVISION)
		|=> r_q.excReq && r_q.excVec == VEC_FORMAT && !r_q.restoreOk;
	endproperty
	a_revision: assert property (p_revision) else $error("mismatch not refused");

	property p_reload;
		@(posedge ref_clk) disable iff (!rst_b)
		r_q.moveLoad |-> r_q.restoreOk && $past(stkFsw[FSW_MULTI]);
	endproperty
	a_reload: assert property (p_reload) else $error("count reload without flag");

	property p_dyn;
		@(posedge ref_clk) disable iff (!rst_b)
		(r_q.st == ST_IDLE && faultReq && dynSized) |=> r_q.faultAddr[0] == 1'b0;
	endproperty
	a_dyn: assert property (p_dyn) else $error("upper byte address not kept");

	c_normal: cover property (@(posedge ref_clk) disable iff (!rst_b)
		r_q.frameDone && r_q.fsw[15:14] == KIND_NORMAL);
	c_multi: cover property (@(posedge ref_clk) disable iff (!rst_b)
		r_q.frameDone && r_q.fsw[15:14] == KIND_MULTI);
	c_nested: cover property (@(posedge ref_clk) disable iff (!rst_b)
		r_q.frameDone && r_q.shortFr);
	c_restore: cover property (@(posedge ref_clk) disable iff (!rst_b) r_q.moveLoad);
endmodule // bfs_fault_frame
`default_nettype wire

// ---- rtl/bfs_frame_word.sv ----
`timescale 1ns/1ps
`default_nettype none
module bfs_frame_word
	import bfs_pkg::*;
(
	// frame contents
	input wire logic [15:0] srWord,
	input wire logic [31:0] retPc,
	input wire logic [15:0] fmtWord,
	input wire logic [31:0] faultAddr,
	input wire logic [31:0] dataHold,
	input wire logic [31:0] curPc,
	input wire logic [15:0] xferWord,
	input wire logic [15:0] fswWord,
	input wire logic shortFrame,
	// selection
	input wire logic [7:0] offset,
	output logic [15:0] word
);
	always_comb begin
		word = 16'h0000;
		if (shortFrame && offset == OFF_XCNT_SHORT) begin
			word = xferWord;
		end else if (shortFrame && offset == OFF_FSW_SHORT) begin
			word = fswWord;
		end else if (shortFrame && offset >= OFF_XCNT) begin
			// slots freed by the missing pc stay empty
			word = 16'h0000;
		end else begin
			case (offset)
				OFF_SR: word = srWord;
				OFF_RPC: word = retPc[31:16];
				OFF_RPC + 8'h02: word = retPc[15:0];
				OFF_FMT: word = fmtWord;
				OFF_FADDR: word = faultAddr[31:16];
				OFF_FADDR + 8'h02: word = faultAddr[15:0];
				OFF_DHOLD: word = dataHold[31:16];
				OFF_DHOLD + 8'h02: word = dataHold[15:0];
				OFF_CPC: word = curPc[31:16];
				OFF_CPC + 8'h02: word = curPc[15:0];
				OFF_XCNT: word = xferWord;
				OFF_FSW: word = fswWord;
				default: word = 16'h0000;
			endcase
		end
	end
endmodule // bfs_frame_word
`default_nettype wire

// ---- rtl/bfs_op_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module bfs_op_decode
	import bfs_pkg::*;
(
	// opcode in
	input wire logic [15:0] opcode,
	input wire logic opValid,
	// classification
	output logic isBreak,
	output logic isLine,
	output logic [7:0] lineVec
);
	always_comb begin
		isBreak = opValid && opcode >= BKPT_LO && opcode <= BKPT_HI;
		isLine = opValid && (opcode[15:12] == LINE_A || opcode[15:12] == LINE_F);
		// separate vectors keep emulation off the illegal-opcode path
		lineVec = (opcode[15:12] == LINE_A) ? VEC_LINE_A : VEC_LINE_F;
	end
endmodule // bfs_op_decode
`default_nettype wire

// ---- rtl/bfs_pkg.sv ----
package bfs_pkg;
	localparam int WORDS_FRAME = 12;
	localparam logic [3:0] FRAME_WORDS = 4'hc;
	// byte offsets within the frame, relative to final stack pointer
	localparam logic [7:0] OFF_SR = 8'h00;
	localparam logic [7:0] OFF_RPC = 8'h02;
	localparam logic [7:0] OFF_FMT = 8'h06;
	localparam logic [7:0] OFF_FADDR = 8'h08;
	localparam logic [7:0] OFF_DHOLD = 8'h0c;
	localparam logic [7:0] OFF_CPC = 8'h10;
	localparam logic [7:0] OFF_XCNT = 8'h14;
	localparam logic [7:0] OFF_FSW = 8'h16;
	localparam logic [7:0] OFF_XCNT_SHORT = 8'h10;
	localparam logic [7:0] OFF_FSW_SHORT = 8'h12;
	localparam logic [7:0] FRAME_BYTES = 8'h18;
	localparam logic [31:0] NESTED_GAP = 32'h0000_0006;
	localparam logic [3:0] FMT_BUS_FAULT = 4'hc;
	localparam logic [3:0] FMT_SHORT = 4'h0;
	// fault status word fields
	localparam int FSW_TYPE = 15;
	localparam int FSW_MULTI = 14;
	localparam int FSW_ZERO = 13;
	localparam logic [1:0] KIND_NORMAL = 2'h0;
	localparam logic [1:0] KIND_MULTI = 2'h1;
	localparam logic [1:0] KIND_NESTED = 2'h2;
	// opcode decode
	localparam logic [15:0] BKPT_LO = 16'h4848;
	localparam logic [15:0] BKPT_HI = 16'h484f;
	localparam logic [3:0] LINE_A = 4'ha;
	localparam logic [3:0] LINE_F = 4'hf;
	// vector numbers
	localparam logic [7:0] VEC_ILLEGAL = 8'h04;
	localparam logic [7:0] VEC_LINE_A = 8'h0a;
	localparam logic [7:0] VEC_LINE_F = 8'h0b;
	localparam logic [7:0] VEC_TRACE = 8'h09;
	localparam logic [7:0] VEC_FORMAT = 8'h0e;
	localparam logic [7:0] VEC_BUSFAULT = 8'h02;
	// register port map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_FSW = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_COUNT = 4'h3;
	localparam int CTRL_TRACE = 0;
	localparam int CTRL_FLOW = 1;
endpackage

// ---- testbench/bfs_stack_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module bfs_stack_mem (
	// clock
	input wire logic ref_clk,
	// stack write port
	input wire logic stkWr,
	input wire logic [31:0] stkAddr,
	input wire logic [15:0] stkData
);
	// 64 KiB word window; unwritten slots read back unknown so stale data never matches
	logic [15:0] mem [0:32767];
	int writes = 0;
	int orderFaults = 0;
	logic [31:0] lastAddr = '0;
	always @(posedge ref_clk) begin
		if (stkWr === 1'b1) begin
			// each word must sit just below the one before it
			if (writes > 0 && stkAddr !== lastAddr - 32'h2)
				orderFaults++;
			mem[stkAddr[15:1]] = stkData;
			lastAddr = stkAddr;
			writes++;
		end
	end
endmodule // bfs_stack_mem
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bfs_pkg::*;
	localparam logic [7:0] REV = 8'h3c; // arbitrary value
	logic ref_clk = 0, rst_b = 0, regWr = 0, regRd = 0, faultReq = 0, inException = 0;
	logic inMultiMove = 0, dynSized = 0, shortFaulted = 0, restoreReq = 0, opDone = 0;
	logic flowChange = 0;
	logic [3:0] regAddr = '0;
	logic [15:0] regWdata = '0, srWord = 16'h2704, stkXfer = '0, stkFsw = '0, opcode = '0;
	logic [12:0] busState = 13'h0a5a;
	logic [31:0] cycleAddr = '0, dataHold = 32'hdead_beef, retPc = 32'h0001_2340;
	logic [31:0] curPc = 32'h0001_233c, stackPtr = '0, priorSp = '0;
	logic [7:0] vecOffset = 8'h08, moveCount = 8'h05;
	logic [15:0] regRdata, stkData;
	logic [31:0] stkAddr, newSp;
	logic stkWr, frameDone, moveLoad, moveContinue, restoreOk, excReq;
	logic [7:0] moveReload, excVec;
	logic sawOk, sawLoad, sawExc;
	logic [7:0] vec, reload;
	logic [15:0] rdv;
	int errors = 0, checks_done = 0;

	always #25 ref_clk = ~ref_clk;

	bfs_fault_frame #(.REVISION(REV)) i_bfs_fault_frame (.ref_clk(ref_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .faultReq(faultReq), .inException(inException),
		.inMultiMove(inMultiMove), .dynSized(dynSized), .cycleAddr(cycleAddr),
		.busState(busState), .dataHold(dataHold), .srWord(srWord), .retPc(retPc),
		.curPc(curPc), .vecOffset(vecOffset), .moveCount(moveCount), .stackPtr(stackPtr),
		.priorSp(priorSp), .shortFaulted(shortFaulted), .restoreReq(restoreReq),
		.stkXfer(stkXfer), .stkFsw(stkFsw), .opcode(opcode), .opDone(opDone),
		.flowChange(flowChange), .stkWr(stkWr), .stkAddr(stkAddr), .stkData(stkData),
		.newSp(newSp), .frameDone(frameDone), .moveLoad(moveLoad), .moveReload(moveReload),
		.moveContinue(moveContinue), .restoreOk(restoreOk), .excReq(excReq), .excVec(excVec));

	bfs_stack_mem i_bfs_stack_mem (.ref_clk(ref_clk), .stkWr(stkWr), .stkAddr(stkAddr),
		.stkData(stkData));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// stack word at a byte address, through the model's window
	function automatic logic [15:0] sw(input logic [31:0] a);
		return i_bfs_stack_mem.mem[a[15:1]];
	endfunction

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask

	// clears the opDone and restoreReq requests, then gathers answers for a few cycles
	task automatic watch();
		sawOk = 0;
		sawLoad = 0;
		sawExc = 0;
		repeat (4) begin
			@(posedge ref_clk);
			opDone <= 1'b0;
			restoreReq <= 1'b0;
			#1;
			if (restoreOk === 1'b1) sawOk = 1;
			if (moveLoad === 1'b1) begin
				sawLoad = 1;
				reload = moveReload;
			end
			if (excReq === 1'b1) begin
				sawExc = 1;
				vec = excVec;
			end
		end
	endtask

	task automatic op(input logic [15:0] code, input logic flow, input logic want,
			input logic [7:0] v);
		@(posedge ref_clk);
		opcode <= code;
		flowChange <= flow;
		opDone <= 1'b1;
		watch();
		chk(sawExc, want, "exception request");
		if (want) chk(vec, v, "exception vector");
	endtask

	task automatic restore(input logic [15:0] xw, input logic [15:0] fw, input logic ok,
			input logic ld);
		@(posedge ref_clk);
		stkXfer <= xw;
		stkFsw <= fw;
		restoreReq <= 1'b1;
		watch();
		chk(sawOk, ok, "restore accepted");
		chk(sawExc, !ok, "format error raised");
		if (!ok) chk(vec, VEC_FORMAT, "format vector");
		chk(sawLoad, ld, "move count reload");
		if (ld) chk(reload, xw[7:0], "reloaded count");
		if (ok) chk(moveContinue, ld, "move continues");
		$display("test done: restore %h %h", xw, fw);
	endtask

	task automatic fault(input logic ex, input logic mm, input logic dyn, input logic sh,
			input logic [31:0] sp, input logic [31:0] addr);
		logic [31:0] base, fsp, fa;
		logic [15:0] fsw, xw;
		int n;
		base = ex ? sp - 32'h6 : sp;
		fsp = base - 32'h18;
		fa = dyn ? {addr[31:1], 1'b0} : addr;
		fsw = {ex, mm, 1'b0, busState};
		// the move count is only carried for a fault inside a multi-register move
		xw = {REV, (mm && !ex) ? moveCount : 8'h00};
		i_bfs_stack_mem.writes = 0;
		@(posedge ref_clk);
		inException <= ex;
		inMultiMove <= mm;
		dynSized <= dyn;
		shortFaulted <= sh;
		stackPtr <= ex ? 32'h0000_0f00 : sp;
		priorSp <= sp;
		cycleAddr <= addr;
		faultReq <= 1'b1;
		@(posedge ref_clk);
		faultReq <= 1'b0;
		n = 0;
		while (frameDone !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk(frameDone, 1'b1, "frame finished");
		chk(newSp, fsp, "final stack pointer");
		@(posedge ref_clk);
		#1 chk(i_bfs_stack_mem.writes, 12, "words pushed");
		chk(i_bfs_stack_mem.orderFaults, 0, "descending writes");
		chk(sw(fsp), srWord, "status register");
		chk({sw(fsp + 32'h2), sw(fsp + 32'h4)}, retPc, "return pc");
		chk(sw(fsp + 32'h6), {FMT_BUS_FAULT, 4'h0, vecOffset}, "format word");
		chk({sw(fsp + 32'h8), sw(fsp + 32'ha)}, fa, "fault address");
		chk({sw(fsp + 32'hc), sw(fsp + 32'he)}, dataHold, "data hold");
		if (sh) begin
			chk(sw(fsp + 32'h10), xw, "short count");
			chk(sw(fsp + 32'h12), fsw, "short status");
			chk({sw(fsp + 32'h14), sw(fsp + 32'h16)}, 32'h0, "empty slots");
		end else begin
			chk({sw(fsp + 32'h10), sw(fsp + 32'h12)}, curPc, "current pc");
			chk(sw(fsp + 32'h14), xw, "count word");
			chk(sw(fsp + 32'h16), fsw, "status word");
		end
		rd(REG_FSW, rdv);
		chk(rdv, fsw, "status register after fault");
		$display("test done: fault %b%b short %b", ex, mm, sh);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		$display("wrong value at %0t: run did not finish", $time);
		wrap_up();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		#1 chk({stkWr, frameDone, excReq, restoreOk, moveLoad}, 5'h0, "outputs in reset");
		rst_b <= 1'b1;
		wr(REG_FSW, 16'h1234);
		rd(REG_FSW, rdv);
		chk(rdv, 16'h1234, "status register readback");
		wr(REG_FSW, 16'hffff);
		rd(REG_FSW, rdv);
		chk(rdv, 16'hdfff, "status bit 13 held low");
		rd(REG_COUNT, rdv);
		chk(rdv, 16'h0, "idle push count");
		rd(REG_STATUS, rdv);
		chk(rdv, 16'h0, "idle status");
		rd(4'hf, rdv);
		chk(rdv, 16'h0, "unmapped register");
		$display("test done: registers");
		fault(0, 0, 1, 0, 32'h0000_1000, 32'h0000_2345);
		fault(0, 1, 0, 0, 32'h0000_2000, 32'h0000_3000);
		fault(1, 0, 0, 0, 32'h0000_3000, 32'h0000_4000);
		fault(1, 0, 0, 1, 32'h0000_4000, 32'h0000_5000);
		restore({REV, 8'h07}, 16'h4000, 1, 1);
		restore({REV, 8'h07}, 16'h0000, 1, 0);
		restore({REV + 8'h1, 8'h07}, 16'h4000, 0, 0);
		for (int i = 0; i < 8; i++)
			op(BKPT_LO + 16'(i), 0, 1, VEC_ILLEGAL);
		op(16'h4847, 0, 0, 8'h0);
		op(16'h4850, 0, 0, 8'h0);
		op(16'ha123, 0, 1, VEC_LINE_A);
		op(16'hf001, 0, 1, VEC_LINE_F);
		$display("test done: opcodes");
		wr(REG_CTRL, 16'h0001);
		op(16'h4e71, 0, 1, VEC_TRACE);
		wr(REG_CTRL, 16'h0003);
		rd(REG_CTRL, rdv);
		chk(rdv, 16'h0003, "control readback");
		op(16'h4e71, 0, 0, 8'h0);
		op(16'h4e71, 1, 1, VEC_TRACE);
		wr(REG_CTRL, 16'h0000);
		op(16'h4e71, 1, 0, 8'h0);
		$display("test done: trace");
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
